// file: bench/direct_pin_io_ports_assertions.sv
// checker: bus answer, direction, output and pull-up relations
// assumes binding to the pin i/o top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module direct_pin_io_ports_assertions (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [11:0] pin_o,
  input wire logic [11:0] pin_oe_o,
  input wire logic [11:0] pullup_en_o
);
  wire ack = !avs_waitrequest_o;
  wire wr_ok = ack && avs_write_i && avs_byteenable_i[0];
  wire dir_req = avs_write_i && avs_address_i == 6'h00;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_ACK_ONE: assert property (ack |=> avs_waitrequest_o [*2])
    else $error("answer not one cycle then idle");
  AST_PULL_ALLOWED: assert property ((pullup_en_o & 12'h70F) == 12'h000)
    else $error("pull-up on a pin without one");
  AST_PULL_INPUT: assert property ((pullup_en_o & pin_oe_o) == 12'h000)
    else $error("pull-up on a driven pin");
  AST_DIR_WR: assert property (wr_ok && avs_address_i == 6'h00 |=>
    pin_oe_o == $past(avs_writedata_i[11:0])) else $error("direction not applied");
  AST_OE_HOLD: assert property ($changed(pin_oe_o) |-> $past(dir_req))
    else $error("direction changed without a write");
  AST_OUT_WR: assert property (wr_ok && avs_address_i == 6'h01 |=>
    pin_o == $past(avs_writedata_i[11:0])) else $error("output bits not applied");
  AST_BYTE_WR: assert property (wr_ok && avs_address_i == 6'h06 |=>
    pin_o == {$past(pin_o[11:8]), $past(avs_writedata_i[7:0])})
    else $error("byte write wrong");
  AST_RD_ZERO: assert property (ack && avs_read_i && avs_address_i == 6'h3F |->
    avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
endmodule // direct_pin_io_ports_assertions
bind direct_pin_io_ports direct_pin_io_ports_assertions u_direct_pin_io_ports_assertions (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .pullup_en_o(pullup_en_o)
);
`default_nettype wire

// file: bench/direct_pin_io_ports_tb.sv
// bench: register access, pad loopback, edge latch, interrupt, pull-ups
// assumes the pad model closes the loop from pin_o back to pin_i
`timescale 1ns/100ps
`default_nettype none
module direct_pin_io_ports_tb;
  localparam int BS = 20;
  localparam int BR = 5;
  localparam int N0 = 30;
  localparam int N4 = 50;
  typedef struct packed {
    logic w; logic [5:0] a; logic [11:0] d; logic [11:0] x; logic [31:0] e;
  } row_t;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdata, q;
  logic wait_rq, irq;
  logic [11:0] pin_lvl, pout, poe, pull;
  logic [11:0] ext_en = 12'hFFF;
  logic [11:0] ext_val = 12'h000;
  int mismatches = 0;
  int compares = 0;
  int lat;
  row_t rows [18] = '{
    '{1'b1, 6'h00, 12'h000, 12'h123, 32'h0000_0000},
    '{1'b0, 6'h02, 12'h000, 12'h123, 32'h0000_0123},
    '{1'b0, 6'h02, 12'h000, 12'h456, 32'h0000_0456},
    '{1'b0, 6'h06, 12'h000, 12'h0A5, 32'h0000_00A5},
    '{1'b1, 6'h00, 12'hFFF, 12'h000, 32'h00FF_F000},
    '{1'b1, 6'h01, 12'hA5C, 12'h000, 32'h00FF_FA5C},
    '{1'b1, 6'h06, 12'h03C, 12'h000, 32'h00FF_FA3C},
    // nibble at pin four, bad lsb refused
    '{1'b1, 6'h07, 12'h004, 12'h000, 32'h00FF_FA3C},
    '{1'b1, 6'h08, 12'h009, 12'h000, 32'h00FF_FA9C},
    '{1'b1, 6'h07, 12'h005, 12'h000, 32'h00FF_FA9C},
    '{1'b0, 6'h07, 12'h000, 12'h000, 32'h0000_0004},
    '{1'b1, 6'h00, 12'h0F0, 12'h000, 32'h000F_0A9C},
    '{1'b1, 6'h05, 12'hFFF, 12'h000, 32'h000F_0A9C},
    '{1'b0, 6'h05, 12'h000, 12'h000, 32'h0000_08F0},
    // nibble read of driven pins, busy idle, direction readback
    '{1'b0, 6'h08, 12'h000, 12'h000, 32'h0000_0009},
    '{1'b0, 6'h0B, 12'h000, 12'h000, 32'h0000_0000},
    '{1'b0, 6'h00, 12'h000, 12'h000, 32'h0000_00F0},
    '{1'b0, 6'h3F, 12'h000, 12'h000, 32'h0000_0000}};
  always #4 core_clk_i = ~core_clk_i;
  direct_pin_io_ports #(.BYTE_SAMPLE_CYC(BS), .BYTE_RET_CYC(BR), .NIB0_CYC(N0),
    .NIB4_CYC(N4)) u_direct_pin_io_ports (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq), .pin_i(pin_lvl),
    .pin_o(pout), .pin_oe_o(poe), .pullup_en_o(pull), .irq_o(irq));
  pin_pad_model u_pin_pad_model (.clk_i(core_clk_i), .pin_o_i(pout), .oe_i(poe),
    .pull_i(pull), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_lvl));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    lat = 0;
    @(posedge core_clk_i);
    while (wait_rq !== 1'b0) begin
      @(posedge core_clk_i);
      lat++;
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic pulse;
    ext_val[0] <= 1'b0;
    repeat (30) @(posedge core_clk_i);
    ext_val[0] <= 1'b1;
    repeat (10) @(posedge core_clk_i);
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    check({6'h00, wait_rq, irq, poe, pull}, 32'h0200_0000);
    foreach (rows[i]) begin
      ext_val <= rows[i].x;
      repeat (6) @(posedge core_clk_i);
      av(rows[i].w, rows[i].a, {20'h00000, rows[i].d});
      check(rows[i].w ? {8'h00, poe, pout} : q, rows[i].e);
    end
    be <= 4'hE;
    av(1'b1, 6'h01, 32'h0000_0FFF);
    be <= 4'hF;
    check({8'h00, poe, pout}, 32'h000F_0A9C);
    av(1'b0, 6'h06, 32'h0000_0000);
    check({q[31:1], lat >= BS + BR}, 32'h0000_0091);
    for (int k = 0; k <= 4; k += 4) begin
      av(1'b1, 6'h07, k);
      av(1'b1, 6'h08, 32'h0000_0006);
      check({31'h0, lat >= N0 + k * (N4 - N0) / 4}, 32'h1);
    end
    ext_val <= 12'h001;
    av(1'b1, 6'h03, 32'h0000_0001);
    av(1'b1, 6'h0A, 32'h0000_0001);
    av(1'b1, 6'h09, 32'h0000_01FF);
    pulse;
    check({31'h0, irq}, 32'h1);
    av(1'b0, 6'h04, 32'h0000_0000);
    check(q & 32'h1, 32'h1);
    av(1'b0, 6'h04, 32'h0000_0000);
    check(q & 32'h1, 32'h0);
    av(1'b1, 6'h09, 32'h0000_0001);
    repeat (3) @(posedge core_clk_i);
    check({31'h0, irq}, 32'h0);
    av(1'b1, 6'h0A, 32'h0000_0000);
    pulse;
    check({31'h0, irq}, 32'h0);
    av(1'b0, 6'h09, 32'h0000_0000);
    check(q & 32'h1, 32'h1);
    ext_en <= 12'h000;
    repeat (6) @(posedge core_clk_i);
    av(1'b0, 6'h02, 32'h0000_0000);
    check({19'h0, q[11], pull}, 32'h0000_1800);
    wrap_up;
  end
endmodule // direct_pin_io_ports_tb
`default_nettype wire

// file: bench/pin_pad_model.sv
// pad model: external drivers, pull-ups and released lines
// assumes oe high while the design drives a pin
`timescale 1ns/100ps
`default_nettype none
module pin_pad_model (
  input wire logic clk_i,
  input wire logic [11:0] pin_o_i,
  input wire logic [11:0] oe_i,
  input wire logic [11:0] pull_i,
  input wire logic [11:0] ext_en_i,
  input wire logic [11:0] ext_val_i,
  output logic [11:0] level_o
);
  logic [11:0] flt_reg = 12'h000;
  // released lines without a pull-up toggle every cycle
  always @(posedge clk_i) flt_reg <= ~flt_reg;
  assign level_o = (oe_i & pin_o_i) | (~oe_i & ext_en_i & ext_val_i)
                 | (~oe_i & ~ext_en_i & (pull_i | flt_reg));
endmodule // pin_pad_model
`default_nettype wire

// file: src/direct_pin_io_ports.v
// direct pin i/o top: twelve pins as bit ports, pins 0-7 also as byte, nibble and edge-latching ports
// assumes an avalon-mm master on core_clk_i and external pads resolving oe
`timescale 1ns/100ps
`default_nettype none
`include "pin_io_defs.vh"
module direct_pin_io_ports #(
  parameter NPINS = `PIO_NPINS,
  parameter CLK_MHZ = `PIO_CLK_MHZ,
  parameter BYTE_SAMPLE_CYC = (`PIO_T_BYTE_SAMPLE_NS * `PIO_CLK_MHZ) / 1000,
  parameter BYTE_RET_CYC = (`PIO_T_BYTE_RET_NS * `PIO_CLK_MHZ) / 1000,
  parameter NIB0_CYC = (`PIO_T_NIB0_NS * `PIO_CLK_MHZ) / 1000,
  parameter NIB4_CYC = (`PIO_T_NIB4_NS * `PIO_CLK_MHZ) / 1000
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire [11:0] pin_i,
  output reg [11:0] pin_o,
  output reg [11:0] pin_oe_o,
  output reg [11:0] pullup_en_o,
  output reg irq_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_ANS = 2'd2;
  localparam OP_NONE = 2'd0;
  localparam OP_BYTE = 2'd1;
  localparam OP_NIB = 2'd2;
  localparam TW = 16;

  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  reg half_reg;
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
    end
  end

  wire [11:0] pin_sync;
  pin_sync #(
    .WIDTH(12)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .en_i(half_reg),
    .pin_i(pin_i),
    .sync_o(pin_sync)
  );

  reg [11:0] dir_reg;
  reg [11:0] out_reg;
  reg [7:0] edge_en_reg;
  reg [7:0] edge_reg;
  reg [11:0] pull_reg;
  reg [2:0] nib_lsb_reg;
  reg [8:0] stat_reg;
  reg [8:0] mask_reg;
  reg [7:0] byte_in_reg;
  reg [11:0] prev_reg;
  reg [1:0] state_reg;
  reg [1:0] op_reg;
  reg [3:0] nib_val_reg;
  reg [31:0] rdata_next;

  wire word_sel = avs_byteenable_i[0];
  wire [7:0] ofs = {avs_address_i, 2'b00};
  wire req = (avs_read_i | avs_write_i) & (state_reg == ST_IDLE);
  wire wr = avs_write_i & (state_reg == ST_IDLE) & word_sel;
  wire rd = avs_read_i & (state_reg == ST_IDLE);
  wire sample_tick = half_reg;
  wire [7:0] fall = prev_reg[7:0] & ~pin_sync[7:0] & edge_en_reg & ~dir_reg[7:0];
  wire edge_read = rd & (ofs == `PIO_OFS_EDGE);
  wire byte_rd = rd & (ofs == `PIO_OFS_BYTE);
  wire nib_wr = wr & (ofs == `PIO_OFS_NIB);

  wire [TW-1:0] nib_cyc = NIB0_CYC[TW-1:0] +
    ((NIB4_CYC[TW-1:0] - NIB0_CYC[TW-1:0]) >> 2) * {13'd0, nib_lsb_reg};
  wire tmr_load = (byte_rd | nib_wr);
  wire [TW-1:0] tmr_cnt = byte_rd ? BYTE_SAMPLE_CYC[TW-1:0] : nib_cyc;
  wire tmr_busy;
  wire tmr_done;
  lat_timer #(
    .W(TW)
  ) u_tmr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .load_i(tmr_load),
    .count_i(tmr_cnt),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );
  reg [TW-1:0] ret_cnt_reg;

  // nibble field of the output image
  wire [11:0] nib_mask = 12'h00F << nib_lsb_reg;
  wire [11:0] nib_bits = {8'h00, nib_val_reg} << nib_lsb_reg;
  wire [11:0] nib_in = pin_sync >> nib_lsb_reg;
  wire [11:0] oe_next = (wr && ofs == `PIO_OFS_DIR) ? avs_writedata_i[11:0] : dir_reg;

  always @* begin
    rdata_next = 32'h0000_0000;
    case (ofs)
      `PIO_OFS_DIR: rdata_next = {20'h0_0000, dir_reg};
      `PIO_OFS_OUT: rdata_next = {20'h0_0000, out_reg};
      `PIO_OFS_IN: rdata_next = {20'h0_0000, pin_sync};
      `PIO_OFS_EDGE_EN: rdata_next = {24'h00_0000, edge_en_reg};
      `PIO_OFS_EDGE: rdata_next = {24'h00_0000, edge_reg};
      `PIO_OFS_PULL: rdata_next = {20'h0_0000, pull_reg};
      `PIO_OFS_NIB_CFG: rdata_next = {29'h0000_0000, nib_lsb_reg};
      `PIO_OFS_NIB: rdata_next = {28'h000_0000, nib_in[3:0]};
      `PIO_OFS_STAT: rdata_next = {23'h00_0000, stat_reg};
      `PIO_OFS_MASK: rdata_next = {23'h00_0000, mask_reg};
      `PIO_OFS_BUSY: rdata_next = {31'h0000_0000, tmr_busy};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pull_reg <= `PIO_PULL_RST;
      dir_reg <= `PIO_DIR_RST;
      out_reg <= 12'h000;
      edge_en_reg <= 8'h00;
      edge_reg <= 8'h00;
      nib_lsb_reg <= 3'd0;
      stat_reg <= 9'h000;
      mask_reg <= 9'h000;
      byte_in_reg <= 8'h00;
      prev_reg <= 12'hFFF;
      state_reg <= ST_IDLE;
      op_reg <= OP_NONE;
      nib_val_reg <= 4'h0;
      ret_cnt_reg <= {TW{1'b0}};
      avs_readdata_o <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
      pin_o <= 12'h000;
      pin_oe_o <= 12'h000;
      pullup_en_o <= 12'h000;
      irq_o <= 1'b0;
    end else begin
      if (sample_tick) begin
        prev_reg <= pin_sync;
      end
      edge_reg <= (edge_read ? 8'h00 : edge_reg) | (sample_tick ? fall : 8'h00);
      stat_reg[7:0] <= stat_reg[7:0] | (sample_tick ? fall : 8'h00);
      stat_reg[8] <= stat_reg[8] | tmr_done;
      avs_waitrequest_o <= 1'b1;
      if (wr) begin
        case (ofs)
          `PIO_OFS_DIR: dir_reg <= avs_writedata_i[11:0];
          `PIO_OFS_OUT: out_reg <= avs_writedata_i[11:0];
          `PIO_OFS_EDGE_EN: edge_en_reg <= avs_writedata_i[7:0];
          `PIO_OFS_PULL: pull_reg <= avs_writedata_i[11:0] & `PIO_PULL_ALLOWED;
          `PIO_OFS_BYTE: out_reg[7:0] <= avs_writedata_i[7:0];
          `PIO_OFS_NIB_CFG: begin
            if (avs_writedata_i[2:0] <= 3'd4) begin
              nib_lsb_reg <= avs_writedata_i[2:0];
            end
          end
          `PIO_OFS_NIB: nib_val_reg <= avs_writedata_i[3:0];
          `PIO_OFS_STAT: begin
            stat_reg[7:0] <= (stat_reg[7:0] & ~avs_writedata_i[7:0]) |
              (sample_tick ? fall : 8'h00);
            stat_reg[8] <= (stat_reg[8] & ~avs_writedata_i[8]) | tmr_done;
          end
          `PIO_OFS_MASK: mask_reg <= avs_writedata_i[8:0];
          default: begin
          end
        endcase
      end
      case (state_reg)
        ST_IDLE: begin
          if (byte_rd) begin
            state_reg <= ST_WAIT;
            op_reg <= OP_BYTE;
          end else if (nib_wr) begin
            state_reg <= ST_WAIT;
            op_reg <= OP_NIB;
          end else if (req) begin
            avs_readdata_o <= rdata_next;
            avs_waitrequest_o <= 1'b0;
            state_reg <= ST_ANS;
          end
        end
        ST_WAIT: begin
          if (tmr_done) begin
            if (op_reg == OP_BYTE) begin
              byte_in_reg <= pin_sync[7:0];
              ret_cnt_reg <= BYTE_RET_CYC[TW-1:0];
            end else begin
              out_reg <= (out_reg & ~nib_mask) | nib_bits;
              ret_cnt_reg <= {TW{1'b0}};
            end
          end else if (!tmr_busy) begin
            if (ret_cnt_reg > {TW{1'b0}}) begin
              ret_cnt_reg <= ret_cnt_reg - {{(TW-1){1'b0}}, 1'b1};
            end else begin
              avs_readdata_o <= (op_reg == OP_BYTE) ? {24'h00_0000, byte_in_reg} :
                32'h0000_0000;
              avs_waitrequest_o <= 1'b0;
              state_reg <= ST_ANS;
            end
          end
        end
        ST_ANS: begin
          state_reg <= ST_IDLE;
          op_reg <= OP_NONE;
        end
        default: state_reg <= ST_IDLE;
      endcase
      pin_oe_o <= oe_next;
      pin_o <= out_reg;
      pullup_en_o <= pull_reg & ~oe_next;
      irq_o <= |(stat_reg & mask_reg);
    end
  end
endmodule // direct_pin_io_ports
`default_nettype wire

// file: src/lat_timer.v
// down counter for firmware-like access latency, pulses done when it reaches zero
// assumes load is a single-cycle request in the core clock domain
`timescale 1ns/100ps
`default_nettype none
module lat_timer #(
  parameter W = 16
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire load_i,
  input wire [W-1:0] count_i,
  output wire busy_o,
  output reg done_o
);
  reg [W-1:0] cnt_reg;
  reg run_reg;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= {W{1'b0}};
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt_reg <= count_i;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
          run_reg <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
  assign busy_o = run_reg;
endmodule // lat_timer
`default_nettype wire

// file: src/pin_io_defs.vh
// constants for the direct pin i/o block: register offsets, fields, reset values, timing
// assumes a 125 MHz core clock and a word-addressed avalon-mm slave
`ifndef PIN_IO_DEFS_VH
`define PIN_IO_DEFS_VH
`define PIO_CLK_MHZ 125
`define PIO_NPINS 12
// register byte offsets
`define PIO_OFS_DIR 8'h00
`define PIO_OFS_OUT 8'h04
`define PIO_OFS_IN 8'h08
`define PIO_OFS_EDGE_EN 8'h0C
`define PIO_OFS_EDGE 8'h10
`define PIO_OFS_PULL 8'h14
`define PIO_OFS_BYTE 8'h18
`define PIO_OFS_NIB_CFG 8'h1C
`define PIO_OFS_NIB 8'h20
`define PIO_OFS_STAT 8'h24
`define PIO_OFS_MASK 8'h28
`define PIO_OFS_BUSY 8'h2C
// reset values and pull-up mask
`define PIO_DIR_RST 12'h000
`define PIO_PULL_RST 12'h000
`define PIO_PULL_ALLOWED 12'h8F0
// status fields
`define PIO_STAT_EDGE 0
`define PIO_STAT_DONE 8
// latencies in ns at the documented rate
`define PIO_T_BYTE_SAMPLE_NS 24000
`define PIO_T_BYTE_RET_NS 4000
`define PIO_T_NIB0_NS 78000
`define PIO_T_NIB4_NS 125000
`define PIO_T_EDGE_MIN_NS 200
`define PIO_T_SYNC_MIN_NS 220
`endif

// file: src/pin_sync.v
// two-flop synchroniser per pin, sampled on a slower enable pulse
// assumes the enable is a one-cycle pulse in the core clock domain
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 12
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire en_i,
  input wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else if (en_i) begin
          meta_reg[g] <= pin_i[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate
  assign sync_o = sync_reg;
endmodule // pin_sync
`default_nettype wire
